/* File: pkg/cscr_consts.vh */
// Constants for the codec serial control register bank
`ifndef CSCR_CONSTS_VH
`define CSCR_CONSTS_VH
`define CSCR_WORD_BITS 16
`define CSCR_SEL_HI 10
`define CSCR_SEL_LO 9
`define CSCR_SEL_LEFT 2'h0
`define CSCR_SEL_RIGHT 2'h1
`define CSCR_SEL_FUNC 2'h2
`define CSCR_SEL_FMT 2'h3
`define CSCR_APPLY_BIT 8
`define CSCR_LEVEL_HI 7
`define CSCR_SLEEP_BIT 8
`define CSCR_BYPASS_BIT 7
`define CSCR_COMMON_BIT 5
`define CSCR_ZDET_BIT 4
`define CSCR_FORCE_BIT 3
`define CSCR_DEEMPH_HI 2
`define CSCR_DEEMPH_LO 1
`define CSCR_SILENCE_BIT 0
`define CSCR_LOOP_BIT 5
`define CSCR_LAYOUT_HI 4
`define CSCR_LAYOUT_LO 2
`define CSCR_POL_BIT 1
`define CSCR_LEVEL_RST 8'hFF
`define CSCR_LAYOUT_RST 3'h0
`define CSCR_LAYOUT_I2S 3'h5
`define CSCR_LAYOUT_DSP 3'h6
`define CSCR_LAYOUT_RSVD 3'h7
`define CSCR_POL_LAST 3'h4
`define CSCR_ZERO_RUN 65536
`endif

/* File: core/cscr_ctrl_regs.v */
// Serial control port and program register bank of a stereo audio codec
// Summary of operation
// - Four 16-bit program registers, loaded only via the three-wire serial port.
// - Word bits 10:9 select register 0 to 3.
// - Register 0 holds left apply flag bit 8, left level bits 7:0.
// - Apply flag zero only stores level; one applies the stored level.
// - Either apply flag set updates both channels' applied attenuation together.
// - Gain is code/256; 00h mutes, FFh is 0 dB.
// - Register 1 holds right apply flag bit 8, right level bits 7:0.
// - Register 2 bit 8 powers ADC down and zeroes its data.
// - Register 2 bit 7 one bypasses the ADC high-pass filter.
// - Register 2 bit 5 makes left level drive both channels.
// - Register 2 bit 4 enables output cut after 65536 zero bit clocks.
// - Register 2 bit 3 forces DAC to bipolar zero, keeping registers.
// - Register 2 bits 2:1 select de-emphasis off, 48, 44.1, 32 kHz.
// - Register 2 bit 0 soft-mutes both channels by ramping in the filter.
// - Register 3 holds loopback bit 5, format bits 4:2, polarity bit 1.
// - Format codes 000-110 select data layouts; 111 is reserved.
// - Loopback routes ADC to DAC, uses I2S format, not in DSP frame.
// - Polarity zero means left on high; applies to formats 0-4 only.
// - Reset gives 0 dB, individual control, all features off, filter on.
`timescale 1ns/10ps
`include "cscr_consts.vh"
module cscr_ctrl_regs #(
	parameter ZERO_RUN = `CSCR_ZERO_RUN
) (
	input wire mclk,
	input wire reset,
	input wire control_shift_clock,
	input wire control_serial_data,
	input wire control_latch,
	input wire bit_clock_in,
	input wire dac_data_zero,
	output reg [7:0] left_gain_code,
	output reg [7:0] right_gain_code,
	output reg [7:0] left_atten_level,
	output reg [7:0] right_atten_level,
	output reg adc_sleep,
	output reg adc_data_clear,
	output reg hpf_bypass,
	output reg common_atten_select,
	output reg zero_run_detect,
	output reg dac_amp_cut,
	output reg dac_force_bpz,
	output reg [1:0] deemph_select,
	output reg soft_silence,
	output reg loopback_enable,
	output reg [2:0] audio_layout_select,
	output reg [2:0] effective_layout,
	output reg word_clock_polarity,
	output reg polarity_applies,
	output reg layout_reserved
);
	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for pins from outside the mclk domain
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	reg sclk_d_r;
	reg latch_d_r;
	reg bclk_d_r;
	always @(posedge mclk) begin
		if (reset) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			sclk_d_r <= 1'b0;
			latch_d_r <= 1'b0;
			bclk_d_r <= 1'b0;
		end else begin
			sync1_r <= {bit_clock_in, control_latch, control_serial_data, control_shift_clock};
			sync2_r <= sync1_r;
			sclk_d_r <= sync2_r[0];
			latch_d_r <= sync2_r[2];
			bclk_d_r <= sync2_r[3];
		end
	end
	wire sclk_rise = sync2_r[0] & ~sclk_d_r;
	wire latch_rise = sync2_r[2] & ~latch_d_r;
	wire bclk_rise = sync2_r[3] & ~bclk_d_r;

	////////////////////////////////////////////////////////////////////////
	// Shift register, MSB first; word taken only on latch rise
	reg [15:0] shift_r;
	always @(posedge mclk) begin
		if (reset)
			shift_r <= 16'h0000;
		else if (sclk_rise)
			shift_r <= {shift_r[14:0], sync2_r[1]};
	end
	wire [1:0] sel = shift_r[`CSCR_SEL_HI:`CSCR_SEL_LO];
	wire apply = shift_r[`CSCR_APPLY_BIT];
	wire [7:0] level = shift_r[`CSCR_LEVEL_HI:0];
	// Reserved bits from the host are simply not stored

	////////////////////////////////////////////////////////////////////////
	// Field values carried by the word now in the shift register
	// No read path exists at all
	wire word_sleep = shift_r[`CSCR_SLEEP_BIT];
	wire word_bypass = shift_r[`CSCR_BYPASS_BIT];
	wire word_common = shift_r[`CSCR_COMMON_BIT];
	wire word_zdet = shift_r[`CSCR_ZDET_BIT];
	wire word_force = shift_r[`CSCR_FORCE_BIT];
	wire [1:0] word_deemph = shift_r[`CSCR_DEEMPH_HI:`CSCR_DEEMPH_LO];
	wire word_silence = shift_r[`CSCR_SILENCE_BIT];
	wire word_loop = shift_r[`CSCR_LOOP_BIT];
	wire [2:0] word_layout = shift_r[`CSCR_LAYOUT_HI:`CSCR_LAYOUT_LO];
	wire word_pol = shift_r[`CSCR_POL_BIT];

	////////////////////////////////////////////////////////////////////////
	// Next values; every register holds unless a latch addresses it
	reg [7:0] left_level_nxt;
	reg [7:0] right_level_nxt;
	reg [7:0] left_gain_nxt;
	reg [7:0] right_gain_nxt;
	reg sleep_nxt;
	reg bypass_nxt;
	reg common_nxt;
	reg zdet_nxt;
	reg force_nxt;
	reg [1:0] deemph_nxt;
	reg silence_nxt;
	reg loop_nxt;
	reg [2:0] layout_nxt;
	reg pol_nxt;
	always @* begin
		left_level_nxt = left_atten_level;
		right_level_nxt = right_atten_level;
		left_gain_nxt = left_gain_code;
		right_gain_nxt = right_gain_code;
		sleep_nxt = adc_sleep;
		bypass_nxt = hpf_bypass;
		common_nxt = common_atten_select;
		zdet_nxt = zero_run_detect;
		force_nxt = dac_force_bpz;
		deemph_nxt = deemph_select;
		silence_nxt = soft_silence;
		loop_nxt = loopback_enable;
		layout_nxt = audio_layout_select;
		pol_nxt = word_clock_polarity;
		if (latch_rise) begin
			case (sel)
			`CSCR_SEL_LEFT: begin
				left_level_nxt = level;
				if (apply) begin
					left_gain_nxt = level;
					right_gain_nxt = common_atten_select ? level : right_atten_level;
				end
			end
			`CSCR_SEL_RIGHT: begin
				right_level_nxt = level;
				if (apply) begin
					left_gain_nxt = left_atten_level;
					right_gain_nxt = common_atten_select ? left_atten_level : level;
				end
			end
			`CSCR_SEL_FUNC: begin
				sleep_nxt = word_sleep;
				bypass_nxt = word_bypass;
				common_nxt = word_common;
				zdet_nxt = word_zdet;
				force_nxt = word_force;
				deemph_nxt = word_deemph;
				silence_nxt = word_silence;
			end
			`CSCR_SEL_FMT: begin
				loop_nxt = word_loop;
				layout_nxt = word_layout;
				pol_nxt = word_pol;
			end
			default: begin
				left_level_nxt = left_atten_level;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register stage; both gains load on one edge so channels never step apart
	always @(posedge mclk) begin
		if (reset) begin
			left_atten_level <= `CSCR_LEVEL_RST;
			right_atten_level <= `CSCR_LEVEL_RST;
			left_gain_code <= `CSCR_LEVEL_RST;
			right_gain_code <= `CSCR_LEVEL_RST;
			adc_sleep <= 1'b0;
			hpf_bypass <= 1'b0;
			common_atten_select <= 1'b0;
			zero_run_detect <= 1'b0;
			dac_force_bpz <= 1'b0;
			deemph_select <= 2'h0;
			soft_silence <= 1'b0;
			loopback_enable <= 1'b0;
			audio_layout_select <= `CSCR_LAYOUT_RST;
			word_clock_polarity <= 1'b0;
		end else begin
			left_atten_level <= left_level_nxt;
			right_atten_level <= right_level_nxt;
			left_gain_code <= left_gain_nxt;
			right_gain_code <= right_gain_nxt;
			adc_sleep <= sleep_nxt;
			hpf_bypass <= bypass_nxt;
			common_atten_select <= common_nxt;
			zero_run_detect <= zdet_nxt;
			dac_force_bpz <= force_nxt;
			deemph_select <= deemph_nxt;
			soft_silence <= silence_nxt;
			loopback_enable <= loop_nxt;
			audio_layout_select <= layout_nxt;
			word_clock_polarity <= pol_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Derived format controls; loopback overrides layout except DSP frame
	always @(posedge mclk) begin
		if (reset) begin
			adc_data_clear <= 1'b0;
			effective_layout <= `CSCR_LAYOUT_RST;
			polarity_applies <= 1'b1;
			layout_reserved <= 1'b0;
		end else begin
			adc_data_clear <= adc_sleep;
			if (loopback_enable && audio_layout_select != `CSCR_LAYOUT_DSP)
				effective_layout <= `CSCR_LAYOUT_I2S;
			else
				effective_layout <= audio_layout_select;
			polarity_applies <= (audio_layout_select <= `CSCR_POL_LAST);
			layout_reserved <= (audio_layout_select == `CSCR_LAYOUT_RSVD);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Zero-run counter on bit clock edges; saturates to avoid wrap
	reg [16:0] zrun_r;
	always @(posedge mclk) begin
		if (reset) begin
			zrun_r <= 17'h00000;
			dac_amp_cut <= 1'b0;
		end else begin
			if (!zero_run_detect || !dac_data_zero)
				zrun_r <= 17'h00000;
			else if (bclk_rise && zrun_r < ZERO_RUN[16:0])
				zrun_r <= zrun_r + 17'h00001;
			dac_amp_cut <= zero_run_detect && dac_data_zero && (zrun_r >= ZERO_RUN[16:0]);
		end
	end
endmodule // cscr_ctrl_regs

/* File: verif/cscr_host.sv */
// Host model driving the three-wire control port
`timescale 1ns/10ps
module cscr_host (output logic control_shift_clock, control_serial_data, control_latch);
	// Idle link, clock parked low
	initial {control_shift_clock, control_serial_data, control_latch} = 3'h0;
	// Offset keeps the link edges off the mclk grid
	task automatic send(input logic [15:0] w);
		#1.3;
		for (int i = 15; i >= 0; i--) begin
			control_serial_data = w[i];
			#31.25 control_shift_clock = 1;
			#62.5 control_shift_clock = 0;
			#31.25;
		end
		control_latch = 1;
		#125 control_latch = 0;
		control_serial_data = ~control_serial_data; // Inverted, never a stale bit
		#125;
	endtask
endmodule // cscr_host

/* File: verif/cscr_ctrl_regs_sva.sv */
// Checker for the serial control register bank
`timescale 1ns/10ps
module cscr_ctrl_regs_sva #(parameter ZERO_RUN = 65536) (
	input wire mclk, reset, control_latch, dac_data_zero, adc_sleep, adc_data_clear,
	input wire common_atten_select, zero_run_detect, dac_amp_cut, loopback_enable,
	input wire polarity_applies, layout_reserved, input wire [1:0] deemph_select,
	input wire [7:0] left_gain_code, right_gain_code, left_atten_level, right_atten_level,
	input wire [2:0] audio_layout_select, effective_layout);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	int zc;
	// Zero run in mclk cycles; a bit clock is always slower
	always @(posedge mclk) zc <= (reset || !dac_data_zero || !zero_run_detect) ? 0 : zc + 1;
	a_apply_both: assert property ($changed({left_gain_code, right_gain_code}) |->
		left_gain_code == left_atten_level && right_gain_code ==
		(common_atten_select ? left_atten_level : right_atten_level)) else $error("gain pair");
	a_latch_cause: assert property ($changed({left_atten_level, deemph_select}) |->
		$past(control_latch, 3)) else $error("no latch");
	a_sleep_clear: assert property (adc_data_clear == $past(adc_sleep)) else $error("clear");
	a_rsvd_flag: assert property ($stable(audio_layout_select) |->
		layout_reserved == (audio_layout_select == 3'h7)) else $error("reserved");
	a_pol_scope: assert property ($stable(audio_layout_select) |->
		polarity_applies == (audio_layout_select <= 3'h4)) else $error("polarity");
	a_loop_layout: assert property ($stable({loopback_enable, audio_layout_select}) |->
		effective_layout == ((loopback_enable && audio_layout_select != 3'h6) ? 3'h5 :
		audio_layout_select)) else $error("loop layout");
	a_cut_late: assert property ($rose(dac_amp_cut) |-> zc >= ZERO_RUN) else $error("early");
	a_cut_drop: assert property (!dac_data_zero |=> ##[0:1] !dac_amp_cut) else $error("held");
	c_apply: cover property ($changed(right_gain_code));
	c_cut: cover property ($rose(dac_amp_cut));
	c_rsvd: cover property (layout_reserved);
endmodule // cscr_ctrl_regs_sva
////////////////////////////////
bind cscr_ctrl_regs cscr_ctrl_regs_sva #(.ZERO_RUN(ZERO_RUN)) u_sva (.*);

/* File: verif/codec_serial_control_registers_tb.sv */
// Self-checking bench for the serial control register bank
`timescale 1ns/10ps
module codec_serial_control_registers_tb;
	logic mclk = 0, reset = 1, bit_clock_in = 0, dac_data_zero = 0, adc_sleep, adc_data_clear;
	logic control_shift_clock, control_serial_data, control_latch, hpf_bypass, dac_amp_cut;
	logic common_atten_select, zero_run_detect, dac_force_bpz, soft_silence, loopback_enable;
	logic word_clock_polarity, polarity_applies, layout_reserved;
	logic [7:0] left_gain_code, right_gain_code, left_atten_level, right_atten_level;
	logic [1:0] deemph_select;
	logic [2:0] audio_layout_select, effective_layout;
	int fail_count = 0, num_checks = 0;
	// Word, applied gains, stored levels, flags; state carries row to row
	logic [63:0] rows [10] = '{64'h0040_FFFF_40FF_0000, 64'h0220_FFFF_4020_0000,
		64'h0310_4010_4010_0000, 64'h0100_0010_0010_0000, 64'h0592_0010_0010_1A40,
		64'h042D_0010_0010_05A0, 64'h00C0_0010_C010_05A0, 64'h0120_2020_2010_05A0,
		64'h0406_2020_2010_00C0, 64'h0636_2020_2010_00DB};
	wire [47:0] obs = {left_gain_code, right_gain_code, left_atten_level, right_atten_level,
		3'h0, adc_sleep, hpf_bypass, common_atten_select, zero_run_detect, dac_force_bpz,
		deemph_select, soft_silence, loopback_enable, audio_layout_select, word_clock_polarity};
	cscr_ctrl_regs #(.ZERO_RUN(16)) u_dut (.*);
	cscr_host u_host (.*);
	// Clocks unrelated in phase
	always #4 mclk = ~mclk;
	always #62.5 bit_clock_in = ~bit_clock_in;
	////////////////////////////////
	task chk(input logic [47:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Whole run needs about 46 us
	initial begin
		#200us;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge mclk);
		reset <= 0;
		@(posedge mclk);
		#1 chk(obs, 48'hFFFF_FFFF_0000);
		foreach (rows[i]) begin
			u_host.send(rows[i][63:48]);
			chk(obs, rows[i][47:0]);
		end
		// All layout codes with loopback; frame layout keeps its own
		for (int f = 0; f < 8; f++) begin
			u_host.send(16'h0620 | 16'(f << 2));
			chk({audio_layout_select, effective_layout, polarity_applies, layout_reserved},
				{f[2:0], (f == 6) ? 3'h6 : 3'h5, f < 5, f == 7});
		end
		// Long zero run, then data returns
		u_host.send(16'h0410);
		@(posedge mclk) dac_data_zero <= 1;
		repeat (200) @(posedge mclk);
		#1 chk(dac_amp_cut, 0);
		repeat (230) @(posedge mclk);
		#1 chk(dac_amp_cut, 1);
		@(posedge mclk) dac_data_zero <= 0;
		repeat (3) @(posedge mclk);
		#1 chk(dac_amp_cut, 0);
		// Reset again in mid-run with the link idle
		@(posedge mclk) reset <= 1;
		repeat (8) @(posedge mclk);
		reset <= 0;
		@(posedge mclk);
		#1 chk(obs, 48'hFFFF_FFFF_0000);
		chk({effective_layout, polarity_applies, layout_reserved, adc_data_clear, dac_amp_cut},
			7'h08);
		final_report;
	end
endmodule // codec_serial_control_registers_tb
